// ==== chgreg_bank.sv ====
// Charger control register bank behind a two-wire serial slave port.
// Assumes scl/sda pins, request pin and core status are asynchronous to mclk_i.
// What this block does
// RQ1: Writing one to status bit 7 pulses a safety-timer restart, self-clearing.
// RQ2: Reading status bit 7 returns the present request pin level.
// RQ3: Status bit 6 gates the charge indicator output; resets to one.
// RQ4: Status bits 5:4 report charge state: ready, charging, done, fault.
// RQ5: Status bit 3 reads one while operating as boost converter.
// RQ6: In charger operation bits 2:0 give the charger fault code.
// RQ7: In boost operation bits 2:0 give boost fault code; 111 unused.
// RQ8: Control bits 7:6 select input current limit; reset to 00.
// RQ9: Control bits 5:4 set weak-battery threshold; both reset to one.
// RQ10: Control bit 3 enables low-current charge termination; resets to zero.
// RQ11: Control bit 2 disables charging when set; resets to zero.
// RQ12: Control bit 1 selects high-impedance mode; resets to zero.
// RQ13: Control bit 0 selects boost operation; resets to charger operation.
// RQ14: Voltage bits 7:2 hold six-bit charge-voltage code; reset gives 3.54 V.
// RQ15: Voltage bit 1 sets request pin active level; resets to high.
// RQ16: Voltage bit 0 enables the request pin; resets to ignored.
// RQ17: Identity register is read-only: maker code 7:5, part code 4:3.
// RQ18: Control register resets to 0x30.
// RQ19: Voltage register resets to 0x0a.
// RQ20: Registers reached by serial write/read transactions; read-only bits ignore writes.
`timescale 1ns/10ps
`default_nettype none
module chgreg_bank
  import chgreg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h6b,
  parameter logic [2:0] MAKER_CODE = 3'h5,  // Arbitrary value
  parameter logic [1:0] PART_CODE = 2'h1,   // Arbitrary value
  parameter logic [2:0] REV_CODE = 3'h2     // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic host_mode_request_pin_i,
  input wire chgreg_stat_t status_i,
  output logic timer_restart_o,
  output logic stat_enable_o,
  output chgreg_ctrl_t ctrl_o,
  output chgreg_volt_t volt_o,
  output logic host_request_active_o
);

  logic scl_s;
  logic sda_s;
  logic scl_n_s;
  logic sda_n_s;
  logic pin_s;
  chgreg_stat_t stat_s;

  chgreg_sync #(
    .W(9)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({~scl_i, ~sda_i, host_mode_request_pin_i, status_i}),
    .q_o({scl_n_s, sda_n_s, pin_s, stat_s})
  );

  // Bus lines pass inverted so the synchroniser reset reads as an idle high bus, no false edge
  assign scl_s = ~scl_n_s;
  assign sda_s = ~sda_n_s;

  // Bus line edges, seen after synchronisation
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // Register state
  logic stat_en_ff;
  logic restart_ff;
  logic req_act_ff;
  chgreg_ctrl_t ctrl_ff;
  chgreg_volt_t volt_ff;
  logic nxt_stat_en;
  logic nxt_restart;
  logic nxt_req_act;
  chgreg_ctrl_t nxt_ctrl;
  chgreg_volt_t nxt_volt;

  // Serial slave state
  chgreg_state_t state_ff;
  chgreg_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic oe_ff;
  logic nxt_oe;
  logic rw_ff;
  logic nxt_rw;
  logic nack_ff;
  logic nxt_nack;
  logic wr_en;

  // Read data at the current pointer
  logic [2:0] fault_rep;
  logic [7:0] rd_data;

  always_comb
  begin
    fault_rep = stat_s.fault;  // RQ6
    if (stat_s.boost_active && stat_s.fault == FAULT_BOOST_UNUSED)
    begin
      fault_rep = FAULT_NONE;  // RQ7
    end
    unique case (ptr_ff)
      REG_STATUS: rd_data = {pin_s, stat_en_ff, stat_s.charge_state, stat_s.boost_active, fault_rep};  // RQ2 RQ4 RQ5
      REG_CTRL: rd_data = ctrl_ff;
      REG_VOLT: rd_data = volt_ff;
      REG_ID: rd_data = {MAKER_CODE, PART_CODE, REV_CODE};  // RQ17
      default: rd_data = 8'h00;
    endcase
  end

  // Slave sequencing: address, pointer, then data bytes with pointer advance
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    wr_en = 1'b0;
    if (start_det)
    begin
      nxt_state = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end
    else if (stop_det)
    begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          nxt_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == BYTE_BITS)
          begin
            nxt_cnt = 4'h0;
            nxt_oe = 1'b1;
            if (state_ff == ST_ADDR)
            begin
              // Other addresses are left alone until the next start
              nxt_rw = sh_ff[0];
              nxt_oe = (sh_ff[7:1] == DEV_ADDR);
              nxt_state = (sh_ff[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            end
            else if (state_ff == ST_PTR)
            begin
              nxt_ptr = sh_ff;
              nxt_state = ST_PTR_ACK;
            end
            else
            begin
              wr_en = 1'b1;  // RQ20
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK, ST_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            nxt_nack = sda_s;
          end
          else if (scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
            if ((state_ff == ST_ADDR_ACK && rw_ff) || (state_ff == ST_RDATA_ACK && !nack_ff))
            begin
              // Sampled at load time, so the pin level is current per byte
              nxt_tx = rd_data;  // RQ20
              nxt_oe = !rd_data[7];
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ST_RDATA;
            end
            else if (state_ff == ST_ADDR_ACK)
            begin
              nxt_state = ST_PTR;
            end
            else if (state_ff == ST_RDATA_ACK)
            begin
              nxt_state = ST_IDLE;
            end
            else
            begin
              nxt_state = ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_ff == BYTE_BITS)
            begin
              nxt_oe = 1'b0;
              nxt_cnt = 4'h0;
              nxt_state = ST_RDATA_ACK;
            end
            else
            begin
              nxt_tx = {tx_ff[6:0], 1'b0};
              nxt_oe = !tx_ff[6];
            end
          end
        end
      endcase
    end
  end

  // Register writes; status bits 7 and 5:0 and identity bits have no storage to overwrite
  always_comb
  begin
    nxt_stat_en = stat_en_ff;
    nxt_ctrl = ctrl_ff;
    nxt_volt = volt_ff;
    nxt_restart = 1'b0;
    if (wr_en)
    begin
      unique case (ptr_ff)
        REG_STATUS:
        begin
          nxt_restart = sh_ff[STAT_RESTART_BIT];  // RQ1
          nxt_stat_en = sh_ff[STAT_EN_BIT];  // RQ3
        end
        REG_CTRL: nxt_ctrl = chgreg_ctrl_t'(sh_ff);  // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13
        REG_VOLT: nxt_volt = chgreg_volt_t'(sh_ff);  // RQ14 RQ15 RQ16
        default:
        begin
          nxt_restart = 1'b0;  // RQ17
        end
      endcase
    end
    nxt_req_act = volt_ff.request_pin_enable && (pin_s == volt_ff.request_pin_polarity);  // RQ15 RQ16
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_en_ff <= STAT_EN_RST;  // RQ3
      ctrl_ff <= CTRL_RST;  // RQ18
      volt_ff <= VOLT_RST;  // RQ19
      restart_ff <= 1'b0;
      req_act_ff <= 1'b0;
    end
    else
    begin
      stat_en_ff <= nxt_stat_en;
      ctrl_ff <= nxt_ctrl;
      volt_ff <= nxt_volt;
      restart_ff <= nxt_restart;
      req_act_ff <= nxt_req_act;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      tx_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      tx_ff <= nxt_tx;
      oe_ff <= nxt_oe;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_ff;
  assign timer_restart_o = restart_ff;
  assign stat_enable_o = stat_en_ff;
  assign ctrl_o = ctrl_ff;
  assign volt_o = volt_ff;
  assign host_request_active_o = req_act_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_restart_pulse: assert property (timer_restart_o |=> !timer_restart_o)  // RQ1
    else $error("timer restart longer than one cycle");

  chk_restart_cause: assert property (timer_restart_o == $past(wr_en && ptr_ff == REG_STATUS && sh_ff[7]))  // RQ1
    else $error("timer restart without a status write of one");

  chk_pin_read: assert property (ptr_ff == REG_STATUS |-> rd_data[7] == pin_s)  // RQ2
    else $error("status bit 7 not the request pin level");

  chk_state_read: assert property (ptr_ff == REG_STATUS |-> rd_data[5:3] == {stat_s.charge_state, stat_s.boost_active})  // RQ4
    else $error("charge state or boost flag misreported");

  chk_boost_fault: assert property ((ptr_ff == REG_STATUS && stat_s.boost_active) |-> rd_data[2:0] != 3'h7)  // RQ7
    else $error("unused boost fault code reported");

  chk_ctrl_write: assert property ((wr_en && ptr_ff == REG_CTRL) |=> ctrl_o == $past(sh_ff))  // RQ8
    else $error("control register write not stored");

  chk_volt_write: assert property ((wr_en && ptr_ff == REG_VOLT) |=> volt_o == $past(sh_ff))  // RQ14
    else $error("voltage register write not stored");

  chk_id_fixed: assert property (ptr_ff == REG_ID |-> rd_data == {MAKER_CODE, PART_CODE, REV_CODE})  // RQ17
    else $error("identity register changed");

  chk_req_active: assert property (##1 host_request_active_o == $past(volt_o.request_pin_enable && pin_s == volt_o.request_pin_polarity))  // RQ16
    else $error("request active does not follow pin, polarity and enable");

  chk_ack_low: assert property (state_ff == ST_WDATA_ACK |-> sda_oe_o)  // RQ20
    else $error("data byte not acknowledged");

endmodule : chgreg_bank
`default_nettype wire

// ==== chgreg_bank_tb.sv ====
// Self-checking bench for the charger register bank.
// Assumes chgreg_host drives the serial pins; data wire has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module chgreg_bank_tb;
  import chgreg_pkg::*;
  localparam logic [6:0] ADDR = 7'h6b;
  localparam logic [7:0] ID = 8'h76;  // Arbitrary value
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin = 1'b0;
  logic scl, sda_m, sda_d, sda_oe, restart, stat_en, req_act, ak;
  logic [7:0] rd, e;
  chgreg_stat_t st = '0;
  chgreg_ctrl_t ctrl;
  chgreg_volt_t volt;
  wire logic sda_w = sda_m & (sda_oe ? sda_d : 1'b1);
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int pulses = 0;
  logic [7:0] pat [7] = '{8'h40, 8'h80, 8'hc5, 8'h3a, 8'hfc, 8'h05, 8'h0a};
  logic [3:0] rq [4] = '{4'hf, 4'hc, 4'ha, 4'h5};

  chgreg_host host_u (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  chgreg_bank #(.DEV_ADDR(ADDR), .MAKER_CODE(ID[7:5]), .PART_CODE(ID[4:3]), .REV_CODE(ID[2:0])) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
    .host_mode_request_pin_i(pin), .status_i(st), .timer_restart_o(restart), .stat_enable_o(stat_en),
    .ctrl_o(ctrl), .volt_o(volt), .host_request_active_o(req_act));

  always #50 mclk_i = ~mclk_i;

  // Whole run needs about 20000 cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (restart === 1'b1)
      pulses++;
    if (cycles == 60000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host_u.write_reg(ADDR, p, d, ak);
    cmp8("write ack", 8'h01, {7'h0, ak});
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] p, input logic [7:0] exp);
    host_u.read_reg(ADDR, p, rd);
    cmp8(what, exp, rd);
  endtask : rdc

  initial
  begin
    tick(6);
    rst_i = 1'b0;
    tick(4);
    cmp8("ctrl reset", CTRL_RST, ctrl);
    cmp8("volt reset", VOLT_RST, volt);
    cmp8("indicator reset", 8'h01, {7'h0, stat_en});
    rdc("ctrl read", REG_CTRL, 8'h30);
    rdc("volt read", REG_VOLT, 8'h0a);
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      e = pat[i];
      wr(i < 4 ? REG_CTRL : REG_VOLT, e);
      if (i < 4)
        cmp8("ctrl port", e, ctrl);
      else
        cmp8("volt port", e, volt);
      rdc("readback", i < 4 ? REG_CTRL : REG_VOLT, e);
    end
    $display("test control done");
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_VOLT, {6'h0, rq[i][3:2]});
      pin = rq[i][1];
      tick(5);
      cmp8("request active", {7'h0, rq[i][0]}, {7'h0, req_act});
    end
    $display("test request pin done");
    pulses = 0;
    wr(REG_STATUS, 8'h7f);
    cmp8("restart pulses", 8'h00, 8'(pulses));
    wr(REG_STATUS, 8'hc0);
    cmp8("restart pulses", 8'h01, 8'(pulses));
    wr(REG_STATUS, 8'h00);
    cmp8("indicator off", 8'h00, {7'h0, stat_en});
    for (int i = 0; i < 16; i++)
    begin
      if (i == 8)
        wr(REG_STATUS, 8'h40);
      st = {i[1:0], i[3], i[2:0]};
      pin = i[0];
      tick(5);
      e = {i[0], i[3], i[1:0], i[3], (i[3] && i[2:0] == 3'h7) ? 3'h0 : i[2:0]};
      rdc("status", REG_STATUS, e);
    end
    $display("test status done");
    rdc("identity", REG_ID, ID);
    wr(REG_ID, ~ID);
    rdc("identity kept", REG_ID, ID);
    rdc("unmapped", 8'h04, 8'h00);
    host_u.write_reg(ADDR ^ 7'h01, REG_CTRL, 8'h55, ak);
    cmp8("foreign ack", 8'h00, {7'h0, ak});
    cmp8("ctrl kept", 8'h3a, ctrl);
    $display("test identity done");
    rst_i = 1'b1;
    tick(2);
    cmp8("ctrl second reset", CTRL_RST, ctrl);
    cmp8("volt second reset", VOLT_RST, volt);
    rst_i = 1'b0;
    tick(4);
    rdc("ctrl after reset", REG_CTRL, CTRL_RST);
    $display("test second reset done");
    conclude();
  end
endmodule : chgreg_bank_tb
`default_nettype wire

// ==== chgreg_host.sv ====
// Bus master model standing in for the host processor.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module chgreg_host (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : hold

  // Six clocks a phase, well above what the pin sampler needs
  task automatic bit_x(input logic b, output logic r);
    hold(1);
    sda_o = b;
    hold(5);
    scl_o = 1'b1;
    hold(3);
    r = sda_i;
    hold(3);
    scl_o = 1'b0;
  endtask : bit_x

  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : byte_x

  task automatic start_c();
    hold(1);
    sda_o = 1'b1;
    hold(5);
    scl_o = 1'b1;
    hold(6);
    sda_o = 1'b0;
    hold(6);
    scl_o = 1'b0;
  endtask : start_c

  task automatic stop_c();
    hold(1);
    sda_o = 1'b0;
    hold(5);
    scl_o = 1'b1;
    hold(6);
    sda_o = 1'b1;
    hold(6);
  endtask : stop_c

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_c();
    byte_x({dev, 1'b0}, q, a0);
    byte_x(p, q, a1);
    byte_x(d, q, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask : write_reg

  // Pointer set by a dataless write, then repeated start; master nacks the byte
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    start_c();
    byte_x({dev, 1'b0}, q, a);
    byte_x(p, q, a);
    start_c();
    byte_x({dev, 1'b1}, q, a);
    byte_x(8'hff, d, a);
    stop_c();
  endtask : read_reg
endmodule : chgreg_host
`default_nettype wire

// ==== chgreg_pkg.sv ====
// Constants and carrier types for the charger control register bank.
// Assumes one 10 MHz clock domain; the serial bus pins are asynchronous.
package chgreg_pkg;

  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_VOLT = 8'h02;
  localparam logic [7:0] REG_ID = 8'h03;

  localparam int STAT_RESTART_BIT = 7;
  localparam int STAT_EN_BIT = 6;
  localparam logic STAT_EN_RST = 1'b1;
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [7:0] VOLT_RST = 8'h0a;

  localparam logic [2:0] FAULT_NONE = 3'h0;
  localparam logic [2:0] FAULT_BOOST_UNUSED = 3'h7;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SYNC_STAGES = 2;
  localparam real CLK_PERIOD_NS = 100.0;

  // Control register, bit 7 first
  typedef struct packed {
    logic [1:0] in_limit;
    logic [1:0] weak_battery_step;
    logic end_of_charge_cutoff_enable;
    logic chg_disable;
    logic input_float_select;
    logic boost_select;
  } chgreg_ctrl_t;

  // Voltage and pin control register, bit 7 first
  typedef struct packed {
    logic [5:0] vreg_code;
    logic request_pin_polarity;
    logic request_pin_enable;
  } chgreg_volt_t;

  // State reported by the charger core
  typedef struct packed {
    logic [1:0] charge_state;
    logic boost_active;
    logic [2:0] fault;
  } chgreg_stat_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } chgreg_state_t;

endpackage : chgreg_pkg

// ==== chgreg_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a level; multi-bit words may be seen mid-change for one cycle.
`timescale 1ns/10ps
`default_nettype none
module chgreg_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule : chgreg_sync
`default_nettype wire
